// >>> pto_pkg.sv
// Package of offsets, field layouts and reset values for the PHY tuning override registers
package pto_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0]  EQ_VALUE_OFFSET     = 8'he8;
  localparam logic [7:0]  OVERRIDE_OFFSET     = 8'hec;
  localparam logic [31:0] EQ_VALUE_RESET      = 32'h0000_0000;
  localparam logic [31:0] OVERRIDE_RESET      = 32'h0000_0000;
  // Writable bits of the override enable word; the rest are reserved zero
  localparam logic [31:0] OVERRIDE_WR_MASK    = 32'h0707_0707;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int          MAX_PORTS           = 4;
  localparam int          FIELD_W             = 4;
  // Equalizer value word: each port owns one byte, init high nibble
  localparam int          EQ_PORT_STRIDE      = 8;
  localparam int          EQ_INIT_LSB         = 4;
  localparam int          EQ_FUNC_LSB         = 0;
  // Swing and de-emphasis word: same byte per port, swing high nibble
  localparam int          SWING_LSB           = 4;
  localparam int          DEEMPH_LSB          = 0;
  // Override enable word: one byte per port
  localparam int          OVR_PORT_STRIDE     = 8;
  localparam int          OVR_EQ_BIT          = 2;
  localparam int          OVR_SWING_BIT       = 1;
  localparam int          OVR_DEEMPH_BIT      = 0;

  // ************************************************************
  // Built-in PHY defaults
  // ************************************************************
  localparam logic [3:0]  DEF_EQ_INIT         = 4'h0;
  localparam logic [3:0]  DEF_EQ_FUNC         = 4'h0;
  localparam logic [3:0]  DEF_SWING           = 4'h0;
  localparam logic [3:0]  DEF_DEEMPH          = 4'h0;

  // ************************************************************
  // Misc widths
  // ************************************************************
  localparam int          CFG_ADDR_W          = 8;
  localparam int          CFG_DATA_W          = 32;
  localparam int          CFG_BE_W            = 4;

endpackage : pto_pkg

// >>> pto_port_sel.sv
// Per-port selector between register values and built-in PHY defaults
`timescale 1ns/1ps
`default_nettype none
module pto_port_sel
  import pto_pkg::*;
#(
  parameter logic [3:0] DEF_INIT   = DEF_EQ_INIT,
  parameter logic [3:0] DEF_FUNC   = DEF_EQ_FUNC,
  parameter logic [3:0] DEF_SW     = DEF_SWING,
  parameter logic [3:0] DEF_DE     = DEF_DEEMPH
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_soft_clr,
  // Port presence
  input  wire logic       i_present,
  // Override bits
  input  wire logic       i_eq_ovr,
  input  wire logic       i_swing_ovr,
  input  wire logic       i_deemph_ovr,
  // Register values
  input  wire logic [3:0] i_eq_init,
  input  wire logic [3:0] i_eq_func,
  input  wire logic [3:0] i_swing,
  input  wire logic [3:0] i_deemph,
  // PHY settings
  output logic      [3:0] o_eq_init,
  output logic      [3:0] o_eq_func,
  output logic      [3:0] o_swing,
  output logic      [3:0] o_deemph
);

  logic use_eq;
  logic use_swing;
  logic use_deemph;

  // Absent ports keep defaults whatever was written
  assign use_eq     = i_present & i_eq_ovr;      // [R03] [R09]
  assign use_swing  = i_present & i_swing_ovr;   // [R09]
  assign use_deemph = i_present & i_deemph_ovr;  // [R09]

  // ************************************************************
  // Registered selection
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_eq_init <= DEF_INIT;
      o_eq_func <= DEF_FUNC;
      o_swing   <= DEF_SW;
      o_deemph  <= DEF_DE;
    end else if (i_soft_clr) begin
      o_eq_init <= DEF_INIT;
      o_eq_func <= DEF_FUNC;
      o_swing   <= DEF_SW;
      o_deemph  <= DEF_DE;
    end else begin
      o_eq_init <= use_eq ? i_eq_init : DEF_INIT;      // [R20] [R03]
      o_eq_func <= use_eq ? i_eq_func : DEF_FUNC;      // [R20] [R03]
      o_swing   <= use_swing ? i_swing : DEF_SW;       // [R20]
      o_deemph  <= use_deemph ? i_deemph : DEF_DE;     // [R20]
    end
  end

endmodule : pto_port_sel
`default_nettype wire

// >>> pto_tuning_regs.sv
// Top of the PHY tuning override register bank with configuration access
//
// Contract
// R01: Equalizer word at 0xE8, RW, resets zero
// R02: Link, global, power-on reset clear both
// R03: Register equalizer used only while override set
// R04: Port 4 init equalizer from bits 31:28
// R05: Port 4 functional equalizer from bits 27:24
// R06: Port 3 equalizer init 23:20, func 19:16
// R07: Port 2 equalizer init 15:12, func 11:8
// R08: Port 1 equalizer init 7:4, func 3:0
// R09: Two-port variant: ports 3,4 writable, ineffective
// R10: Override word at 0xEC, resets zero
// R11: Bits 31:27, 23:19 ignore writes, read zero
// R12: Bit 26 overrides port 4 equalization
// R13: Bit 25 overrides port 4 transmit swing
// R14: Bit 24 overrides port 4 de-emphasis
// R15: Bit 18 overrides port 3 equalization
// R16: Bit 17 overrides port 3 transmit swing
// R17: Bit 16 overrides port 3 de-emphasis
// R18: Port 2 bits 10,9,8; 15:11 read zero
// R19: Port 1 bits 2,1,0; 7:3 read zero
// R20: Each PHY input selects register or default
`timescale 1ns/1ps
`default_nettype none
module pto_tuning_regs
  import pto_pkg::*;
#(
  parameter int NUM_PORTS = MAX_PORTS
) (
  // Clock and power-on reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_ARST_N,
  // Link and global resets from pins
  input  wire logic        I_LINK_RESET_N,
  input  wire logic        I_GLOBAL_RESET_N,
  // Configuration access
  input  wire logic [7:0]  I_CFG_ADDR,
  input  wire logic        I_CFG_WR,
  input  wire logic [3:0]  I_CFG_BE,
  input  wire logic [31:0] I_CFG_WDATA,
  input  wire logic        I_CFG_RD,
  output logic      [31:0] O_CFG_RDATA,
  output logic             O_CFG_RD_VALID,
  // Swing and de-emphasis word from its own register
  input  wire logic [31:0] I_SWING_DEEMPH,
  // Port 1 PHY settings
  output logic      [3:0]  O_P1_EQ_INIT,
  output logic      [3:0]  O_P1_EQ_FUNC,
  output logic      [3:0]  O_P1_TX_SWING,
  output logic      [3:0]  O_P1_DEEMPH,
  // Port 2 PHY settings
  output logic      [3:0]  O_P2_EQ_INIT,
  output logic      [3:0]  O_P2_EQ_FUNC,
  output logic      [3:0]  O_P2_TX_SWING,
  output logic      [3:0]  O_P2_DEEMPH,
  // Port 3 PHY settings
  output logic      [3:0]  O_P3_EQ_INIT,
  output logic      [3:0]  O_P3_EQ_FUNC,
  output logic      [3:0]  O_P3_TX_SWING,
  output logic      [3:0]  O_P3_DEEMPH,
  // Port 4 PHY settings
  output logic      [3:0]  O_P4_EQ_INIT,
  output logic      [3:0]  O_P4_EQ_FUNC,
  output logic      [3:0]  O_P4_TX_SWING,
  output logic      [3:0]  O_P4_DEEMPH
);

  // ************************************************************
  // Functions
  // ************************************************************
  // Byte-enable merge, masked to the bits that hold storage
  function automatic logic [31:0] merge_be(input logic [31:0] old_val,
                                           input logic [31:0] new_val,
                                           input logic [3:0]  be,
                                           input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    merge_be = (old_val & ~lane) | (new_val & lane);
  endfunction : merge_be

  // Nibble of a word at a given port byte and lsb
  function automatic logic [3:0] nib(input logic [31:0] word,
                                     input int          port,
                                     input int          lsb);
    nib = word[port*EQ_PORT_STRIDE+lsb +: FIELD_W];
  endfunction : nib

  // ************************************************************
  // Reset pin synchronisers
  // ************************************************************
  logic link_rst_meta;
  logic link_rst_sync;
  logic glob_rst_meta;
  logic glob_rst_sync;
  logic soft_clr;

  // Held asserted under power-on reset, released two edges after the pin
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      link_rst_meta <= 1'b0;
      link_rst_sync <= 1'b0;
    end else begin
      link_rst_meta <= I_LINK_RESET_N;
      link_rst_sync <= link_rst_meta;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      glob_rst_meta <= 1'b0;
      glob_rst_sync <= 1'b0;
    end else begin
      glob_rst_meta <= I_GLOBAL_RESET_N;
      glob_rst_sync <= glob_rst_meta;
    end
  end

  // Either reset pin clears the bank synchronously
  assign soft_clr = ~link_rst_sync | ~glob_rst_sync;  // [R02]

  // ************************************************************
  // Address decode
  // ************************************************************
  logic hit_eq;
  logic hit_ovr;

  assign hit_eq  = (I_CFG_ADDR == EQ_VALUE_OFFSET);   // [R01]
  assign hit_ovr = (I_CFG_ADDR == OVERRIDE_OFFSET);   // [R10]

  // ************************************************************
  // Write qualification
  // ************************************************************
  // A write that lands under a pin reset is dropped, not deferred
  logic wr_eq;
  logic wr_ovr;

  assign wr_eq  = I_CFG_WR & hit_eq & ~soft_clr;    // [R01] [R02]
  assign wr_ovr = I_CFG_WR & hit_ovr & ~soft_clr;   // [R10] [R02]

  // ************************************************************
  // Port presence
  // ************************************************************
  // Fixed at build time; a two-port build keeps storage for 3 and 4
  logic [MAX_PORTS-1:0] port_present;

  genvar gq;
  generate
    for (gq = 0; gq < MAX_PORTS; gq++) begin : g_present
      assign port_present[gq] = (gq < NUM_PORTS);   // [R09]
    end
  endgenerate

  // ************************************************************
  // Equalizer value register
  // ************************************************************
  logic [31:0] equalizer_value_select;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      equalizer_value_select <= EQ_VALUE_RESET;        // [R01] [R02]
    end else if (soft_clr) begin
      equalizer_value_select <= EQ_VALUE_RESET;        // [R02]
    end else if (wr_eq) begin
      // Absent-port fields still store, they just steer nothing
      equalizer_value_select <= merge_be(equalizer_value_select, I_CFG_WDATA,
                                         I_CFG_BE, '1);  // [R01] [R09]
    end
  end

  // ************************************************************
  // Override enable register
  // ************************************************************
  logic [31:0] phy_tuning_override_enable;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      phy_tuning_override_enable <= OVERRIDE_RESET;    // [R10] [R02]
    end else if (soft_clr) begin
      phy_tuning_override_enable <= OVERRIDE_RESET;    // [R02]
    end else if (wr_ovr) begin
      // Reserved bits never take a one, so they read back zero
      phy_tuning_override_enable <= merge_be(phy_tuning_override_enable,
                                             I_CFG_WDATA, I_CFG_BE,
                                             OVERRIDE_WR_MASK);  // [R11] [R18] [R19]
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [31:0] next_rdata;
  logic [31:0] ovr_readback;

  // Mask again on the way out so reserved bits cannot leak a one
  assign ovr_readback = phy_tuning_override_enable & OVERRIDE_WR_MASK;  // [R11]

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_eq) begin
      next_rdata = equalizer_value_select;
    end else if (hit_ovr) begin
      next_rdata = ovr_readback;  // [R11]
    end
  end

  // Valid pulse one edge after every read strobe
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_CFG_RD_VALID <= 1'b0;
    end else begin
      O_CFG_RD_VALID <= I_CFG_RD;
    end
  end

  // Other offsets belong to other blocks; this bank answers zero there
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_CFG_RDATA <= 32'h0000_0000;
    end else if (I_CFG_RD) begin
      O_CFG_RDATA <= next_rdata;
    end
  end

  // ************************************************************
  // Per-port field extraction and selection
  // ************************************************************
  logic [3:0] sel_eq_init [MAX_PORTS];
  logic [3:0] sel_eq_func [MAX_PORTS];
  logic [3:0] sel_swing   [MAX_PORTS];
  logic [3:0] sel_deemph  [MAX_PORTS];

  genvar gp;
  generate
    for (gp = 0; gp < MAX_PORTS; gp++) begin : g_port
      logic ovr_eq;
      logic ovr_sw;
      logic ovr_de;
      logic [3:0] fld_eq_init;
      logic [3:0] fld_eq_func;
      logic [3:0] fld_swing;
      logic [3:0] fld_deemph;

      // Port n fields sit in byte n of each word
      assign fld_eq_init = nib(equalizer_value_select, gp, EQ_INIT_LSB);  // [R04] [R06] [R07] [R08]
      assign fld_eq_func = nib(equalizer_value_select, gp, EQ_FUNC_LSB);  // [R05] [R06] [R07] [R08]
      assign fld_swing   = nib(I_SWING_DEEMPH, gp, SWING_LSB);            // [R13] [R16]
      assign fld_deemph  = nib(I_SWING_DEEMPH, gp, DEEMPH_LSB);           // [R14] [R17]

      // Port n override bits at byte n: eq, swing, de-emphasis
      assign ovr_eq = phy_tuning_override_enable[gp*OVR_PORT_STRIDE+OVR_EQ_BIT];  // [R12] [R15] [R18] [R19]
      assign ovr_sw = phy_tuning_override_enable[gp*OVR_PORT_STRIDE+OVR_SWING_BIT];  // [R13] [R16]
      assign ovr_de = phy_tuning_override_enable[gp*OVR_PORT_STRIDE+OVR_DEEMPH_BIT];  // [R14] [R17]

      pto_port_sel #(
        .DEF_INIT    (DEF_EQ_INIT),
        .DEF_FUNC    (DEF_EQ_FUNC),
        .DEF_SW      (DEF_SWING),
        .DEF_DE      (DEF_DEEMPH)
      ) u_sel (
        .i_clk       (I_SYS_CLK),
        .i_arst_n    (I_ARST_N),
        .i_soft_clr  (soft_clr),
        .i_present   (port_present[gp]),                               // [R09]
        .i_eq_ovr    (ovr_eq),
        .i_swing_ovr (ovr_sw),
        .i_deemph_ovr(ovr_de),
        .i_eq_init   (fld_eq_init),
        .i_eq_func   (fld_eq_func),
        .i_swing     (fld_swing),
        .i_deemph    (fld_deemph),
        .o_eq_init   (sel_eq_init[gp]),
        .o_eq_func   (sel_eq_func[gp]),
        .o_swing     (sel_swing[gp]),
        .o_deemph    (sel_deemph[gp])
      );
    end
  endgenerate

  // ************************************************************
  // PHY outputs, straight from the selector flops
  // ************************************************************
  assign O_P1_EQ_INIT  = sel_eq_init[0];
  assign O_P1_EQ_FUNC  = sel_eq_func[0];
  assign O_P1_TX_SWING = sel_swing[0];
  assign O_P1_DEEMPH   = sel_deemph[0];
  assign O_P2_EQ_INIT  = sel_eq_init[1];
  assign O_P2_EQ_FUNC  = sel_eq_func[1];
  assign O_P2_TX_SWING = sel_swing[1];
  assign O_P2_DEEMPH   = sel_deemph[1];
  assign O_P3_EQ_INIT  = sel_eq_init[2];
  assign O_P3_EQ_FUNC  = sel_eq_func[2];
  assign O_P3_TX_SWING = sel_swing[2];
  assign O_P3_DEEMPH   = sel_deemph[2];
  assign O_P4_EQ_INIT  = sel_eq_init[3];
  assign O_P4_EQ_FUNC  = sel_eq_func[3];
  assign O_P4_TX_SWING = sel_swing[3];
  assign O_P4_DEEMPH   = sel_deemph[3];

endmodule : pto_tuning_regs
`default_nettype wire

// >>> pto_tuning_regs_assertions.sv
// Port-level checks on the PHY tuning override register bank
`timescale 1ns/1ps
`default_nettype none
module pto_tuning_regs_chk
  import pto_pkg::*;
#(
  parameter int NUM_PORTS = MAX_PORTS
) (
  // Clock and resets
  input wire logic        I_SYS_CLK,
  input wire logic        I_ARST_N,
  input wire logic        I_LINK_RESET_N,
  input wire logic        I_GLOBAL_RESET_N,
  // Configuration access
  input wire logic [7:0]  I_CFG_ADDR,
  input wire logic        I_CFG_RD,
  input wire logic [31:0] O_CFG_RDATA,
  input wire logic        O_CFG_RD_VALID,
  // PHY side
  input wire logic [31:0] I_SWING_DEEMPH,
  input wire logic [3:0]  O_P1_EQ_INIT,
  input wire logic [3:0]  O_P1_TX_SWING,
  input wire logic [3:0]  O_P3_EQ_FUNC,
  input wire logic [3:0]  O_P4_EQ_INIT,
  input wire logic [3:0]  O_P4_DEEMPH
);
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);

  a_rd_answer_next: assert property (I_CFG_RD |=> O_CFG_RD_VALID)
    else $error("read not answered one cycle later");
  a_rd_answer_cause: assert property (O_CFG_RD_VALID |-> $past(I_CFG_RD))
    else $error("read answer without a read");
  a_ovr_reserved_zero_zero: assert property (O_CFG_RD_VALID && $past(I_CFG_ADDR) == OVERRIDE_OFFSET
    |-> (O_CFG_RDATA & ~OVERRIDE_WR_MASK) == 32'h0000_0000) else $error("reserved bits set");
  a_unmapped_zero: assert property (O_CFG_RD_VALID && $past(I_CFG_ADDR) != EQ_VALUE_OFFSET
    && $past(I_CFG_ADDR) != OVERRIDE_OFFSET |-> O_CFG_RDATA == 32'h0) else $error("unmapped read");
  a_p4_init_field: assert property (O_CFG_RD_VALID && $past(I_CFG_ADDR) == EQ_VALUE_OFFSET
    && O_P4_EQ_INIT != DEF_EQ_INIT |-> O_CFG_RDATA[31:28] == O_P4_EQ_INIT) else $error("p4 init");
  a_p3_func_field: assert property (O_CFG_RD_VALID && $past(I_CFG_ADDR) == EQ_VALUE_OFFSET
    && O_P3_EQ_FUNC != DEF_EQ_FUNC |-> O_CFG_RDATA[19:16] == O_P3_EQ_FUNC) else $error("p3 func");
  a_p1_swing_src: assert property (O_P1_TX_SWING != DEF_SWING
    |-> O_P1_TX_SWING == $past(I_SWING_DEEMPH[7:4])) else $error("p1 swing source");
  a_p4_deemph_src: assert property (O_P4_DEEMPH != DEF_DEEMPH
    |-> O_P4_DEEMPH == $past(I_SWING_DEEMPH[27:24])) else $error("p4 de-emphasis source");
  a_pin_reset_clear: assert property ((!I_LINK_RESET_N || !I_GLOBAL_RESET_N) [*5]
    |-> O_P1_EQ_INIT == DEF_EQ_INIT && O_P1_TX_SWING == DEF_SWING && O_P4_DEEMPH == DEF_DEEMPH)
    else $error("pin reset did not clear");

  c_p4_eq_read: cover property (O_CFG_RD_VALID && O_P4_EQ_INIT != DEF_EQ_INIT);
  c_global_clear: cover property (!I_GLOBAL_RESET_N [*5]);
  c_p4_deemph: cover property (O_P4_DEEMPH != DEF_DEEMPH);
endmodule : pto_tuning_regs_chk

bind pto_tuning_regs pto_tuning_regs_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .I_LINK_RESET_N(I_LINK_RESET_N),
  .I_GLOBAL_RESET_N(I_GLOBAL_RESET_N), .I_CFG_ADDR(I_CFG_ADDR), .I_CFG_RD(I_CFG_RD),
  .O_CFG_RDATA(O_CFG_RDATA), .O_CFG_RD_VALID(O_CFG_RD_VALID), .I_SWING_DEEMPH(I_SWING_DEEMPH),
  .O_P1_EQ_INIT(O_P1_EQ_INIT), .O_P1_TX_SWING(O_P1_TX_SWING), .O_P3_EQ_FUNC(O_P3_EQ_FUNC),
  .O_P4_EQ_INIT(O_P4_EQ_INIT), .O_P4_DEEMPH(O_P4_DEEMPH)
);
`default_nettype wire

// >>> pto_phy_model.sv
// Model of the separate swing and de-emphasis word seen by the bank
`timescale 1ns/1ps
`default_nettype none
module pto_phy_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Load request
  input  wire logic        i_load,
  input  wire logic [31:0] i_value,
  // Word fed to the bank
  output logic      [31:0] o_swing_deemph
);
  // Held between loads so an override always sees a steady word
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_swing_deemph <= 32'h0000_0000;
    end else if (i_load) begin
      o_swing_deemph <= i_value;
    end
  end
endmodule : pto_phy_model
`default_nettype wire

// >>> phy_tuning_override_regs_tb_top.sv
// Self-checking bench for the PHY tuning override register bank
`timescale 1ns/1ps
`default_nettype none
module phy_tuning_override_regs_tb_top;
  import pto_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        link_n = 1'b1;
  logic        glob_n = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        sd_ld = 1'b0;
  logic [31:0] sd_in = 32'h1357_9bdf;
  logic [31:0] eq_val = 32'hfedc_ba98;
  wire  [31:0] sd;
  wire  [31:0] rdata;
  wire         rd_valid;
  wire  [15:0] phy [4];
  wire  [15:0] phy2 [2];
  wire  [31:0] rdata2;
  int          fail_count = 0;
  int          compares = 0;

  always #2 clk = ~clk;

  pto_phy_model u_phy (.i_clk(clk), .i_arst_n(arst_n), .i_load(sd_ld), .i_value(sd_in),
    .o_swing_deemph(sd));

  pto_tuning_regs #(.NUM_PORTS(4)) uut (
    .I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_LINK_RESET_N(link_n), .I_GLOBAL_RESET_N(glob_n),
    .I_CFG_ADDR(addr), .I_CFG_WR(wr), .I_CFG_BE(be), .I_CFG_WDATA(wdata), .I_CFG_RD(rd),
    .O_CFG_RDATA(rdata), .O_CFG_RD_VALID(rd_valid), .I_SWING_DEEMPH(sd),
    .O_P1_EQ_INIT(phy[0][15:12]), .O_P1_EQ_FUNC(phy[0][11:8]),
    .O_P1_TX_SWING(phy[0][7:4]), .O_P1_DEEMPH(phy[0][3:0]),
    .O_P2_EQ_INIT(phy[1][15:12]), .O_P2_EQ_FUNC(phy[1][11:8]),
    .O_P2_TX_SWING(phy[1][7:4]), .O_P2_DEEMPH(phy[1][3:0]),
    .O_P3_EQ_INIT(phy[2][15:12]), .O_P3_EQ_FUNC(phy[2][11:8]),
    .O_P3_TX_SWING(phy[2][7:4]), .O_P3_DEEMPH(phy[2][3:0]),
    .O_P4_EQ_INIT(phy[3][15:12]), .O_P4_EQ_FUNC(phy[3][11:8]),
    .O_P4_TX_SWING(phy[3][7:4]), .O_P4_DEEMPH(phy[3][3:0])
  );

  // Two-port build on the same stimulus: ports 3 and 4 must stay at defaults
  pto_tuning_regs #(.NUM_PORTS(2)) uut_two (
    .I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_LINK_RESET_N(link_n), .I_GLOBAL_RESET_N(glob_n),
    .I_CFG_ADDR(addr), .I_CFG_WR(wr), .I_CFG_BE(be), .I_CFG_WDATA(wdata), .I_CFG_RD(rd),
    .O_CFG_RDATA(rdata2), .O_CFG_RD_VALID(), .I_SWING_DEEMPH(sd),
    .O_P1_EQ_INIT(), .O_P1_EQ_FUNC(), .O_P1_TX_SWING(), .O_P1_DEEMPH(),
    .O_P2_EQ_INIT(), .O_P2_EQ_FUNC(), .O_P2_TX_SWING(), .O_P2_DEEMPH(),
    .O_P3_EQ_INIT(phy2[0][15:12]), .O_P3_EQ_FUNC(phy2[0][11:8]),
    .O_P3_TX_SWING(phy2[0][7:4]), .O_P3_DEEMPH(phy2[0][3:0]),
    .O_P4_EQ_INIT(phy2[1][15:12]), .O_P4_EQ_FUNC(phy2[1][11:8]),
    .O_P4_TX_SWING(phy2[1][7:4]), .O_P4_DEEMPH(phy2[1][3:0])
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic final_report();
    $display("Compares %0d, errors %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Leading edge wait keeps the strobe low a cycle between writes
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    be = b;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : cfg_wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    for (int i = 0; i < 4 && rd_valid !== 1'b1; i++) @(negedge clk);
    check("rd_valid", 32'h1, {31'h0, rd_valid});
    check(name, exp, rdata);
    check("two_port_rdata", exp, rdata2);
  endtask : rd_chk

  function automatic logic [3:0] exp_out(input int p, input int k, input logic [31:0] ov);
    logic [7:0] e;
    logic [7:0] s;
    e = eq_val[8*p +: 8];
    s = sd_in[8*p +: 8];
    case (k)
      0: return ov[8*p+2] ? e[7:4] : DEF_EQ_INIT;
      1: return ov[8*p+2] ? e[3:0] : DEF_EQ_FUNC;
      2: return ov[8*p+1] ? s[7:4] : DEF_SWING;
      default: return ov[8*p] ? s[3:0] : DEF_DEEMPH;
    endcase
  endfunction : exp_out

  // Outputs lag the registers by one edge, so settle first
  task automatic check_phy(input logic [31:0] ov);
    repeat (2) @(negedge clk);
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 4; k++) begin
        check("phy_out", {28'h0, exp_out(p, k, ov)}, {28'h0, phy[p][15-4*k -: 4]});
      end
    end
    for (int p = 2; p < 4; p++) begin
      for (int k = 0; k < 4; k++) begin
        check("phy_absent", {28'h0, exp_out(p, k, 32'h0)}, {28'h0, phy2[p-2][15-4*k -: 4]});
      end
    end
  endtask : check_phy

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd_chk("eq_reset", EQ_VALUE_OFFSET, EQ_VALUE_RESET);
    rd_chk("ovr_reset", OVERRIDE_OFFSET, OVERRIDE_RESET);
    sd_ld = 1'b1;
    @(negedge clk);
    sd_ld = 1'b0;
    cfg_wr(EQ_VALUE_OFFSET, 4'hf, eq_val);
    rd_chk("eq_rw", EQ_VALUE_OFFSET, eq_val);
    check_phy(32'h0);
    cfg_wr(OVERRIDE_OFFSET, 4'hf, 32'hffff_ffff);
    rd_chk("ovr_rw", OVERRIDE_OFFSET, 32'h0707_0707);
    check_phy(32'h0707_0707);
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 3; b++) begin
        cfg_wr(OVERRIDE_OFFSET, 4'hf, 32'h1 << (8*p + b));
        check_phy(32'h1 << (8*p + b));
      end
    end
    cfg_wr(OVERRIDE_OFFSET, 4'hf, 32'hf8f8_f8f8);
    rd_chk("ovr_reserved_zero", OVERRIDE_OFFSET, 32'h0);
    cfg_wr(EQ_VALUE_OFFSET, 4'h2, 32'h0);
    rd_chk("eq_byte", EQ_VALUE_OFFSET, 32'hfedc_0098);
    cfg_wr(8'hf0, 4'hf, 32'hffff_ffff);
    rd_chk("unmapped", 8'hf0, 32'h0);
    // Both pin resets in turn; each must wipe values and overrides
    for (int r = 0; r < 2; r++) begin
      cfg_wr(EQ_VALUE_OFFSET, 4'hf, eq_val);
      cfg_wr(OVERRIDE_OFFSET, 4'hf, 32'h0707_0707);
      @(negedge clk);
      link_n = (r != 0);
      glob_n = (r == 0);
      repeat (6) @(negedge clk);
      link_n = 1'b1;
      glob_n = 1'b1;
      repeat (3) @(negedge clk);
      rd_chk("eq_pin_clr", EQ_VALUE_OFFSET, 32'h0);
      rd_chk("ovr_pin_clr", OVERRIDE_OFFSET, 32'h0);
      check_phy(32'h0);
    end
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule : phy_tuning_override_regs_tb_top
`default_nettype wire
